// file: rtl/watchdog_reset_supervisor.sv
// Watchdog timer, power-on reset supervisor and strap decoding with APB registers
// How it works
// - Missed service pulls timeout output low 202 ms
// - New timeout after 1.62 s idle or 12.9 s
// - Reset restarts watchdog with one timeout period
// - Timeout output only sinks, never drives high
// - All delays scale with timing capacitor value
// - Capacitor pin at rail disables the watchdog
// - Reset low while enabled feedback out of window
// - Window -2%/+7.5% reg1, -5%/+7.5% others
// - Reset low while all regulators disabled
// - Reset release delayed by capacitor-scaled interval
// - Only enabled regulators take part in monitoring
// - Three strap bits select power stage grouping
// - Frequency pin at rail selects internal oscillator when no sync clock is present
// - Sync clock: high-voltage side runs at one sixth
// - Mode pin selects burst, forced or skipping operation
// - All regulators off shuts temperature monitor down
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module watchdog_reset_supervisor
  import wd_supervisor_pkg::*;
#(
  parameter int UNIT_CYC = UNIT_CYC_PER_NF
) (
  // Clock and undervoltage reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Watchdog pins
  input wire logic watchdog_service_in,
  input wire logic timing_cap_pin,
  output logic watchdog_timeout_out_o,
  output logic watchdog_timeout_out_oe,
  // Regulator enables and feedback codes in mV
  input wire logic reg1_enable,
  input wire logic reg2_enable,
  input wire logic reg3_enable,
  input wire logic reg4_enable,
  input wire logic [FB_W-1:0] reg1_feedback,
  input wire logic [FB_W-1:0] reg2_feedback,
  input wire logic [FB_W-1:0] reg3_feedback,
  input wire logic [FB_W-1:0] reg4_feedback,
  // Reset output pin
  output logic rstOut_o,
  output logic rstOut_oe,
  // Straps and clocking
  input wire logic stage_config_bit0,
  input wire logic stage_config_bit1,
  input wire logic stage_config_bit2,
  input wire logic freq_set_pin,
  input wire logic syncPresent,
  input wire logic syncClkIn,
  input wire logic [1:0] modeLevel,
  output logic [2:0] stageConfig,
  output logic internalOscSel,
  output logic lvSyncPulse,
  output logic hvSyncPulse,
  output logic forcedCont,
  output logic lvBurst,
  output logic hvBurst,
  output logic hvSkip,
  output logic tempMonEnable
);

  function automatic logic inWindow(input logic [FB_W-1:0] fb, input logic [FB_W-1:0] low);
    inWindow = (fb >= low) && (fb <= PG_HIGH_MV);
  endfunction : inWindow

  logic [3:0] enVec;
  logic [FB_W-1:0] fbVec [4];
  logic [3:0] pgOk;
  logic anyEn;
  logic allEnabledOk;

  assign enVec = {reg4_enable, reg3_enable, reg2_enable, reg1_enable};
  assign fbVec[0] = reg1_feedback;
  assign fbVec[1] = reg2_feedback;
  assign fbVec[2] = reg3_feedback;
  assign fbVec[3] = reg4_feedback;

  // Disabled regulators count as good so they cannot hold reset
  generate
    for (genvar i = 0; i < 4; i++) begin : g_pg
      if (i == 0) begin : g_r1
        assign pgOk[i] = !enVec[i] || inWindow(fbVec[i], PG_R1_LOW_MV);
      end else begin : g_rx
        assign pgOk[i] = !enVec[i] || inWindow(fbVec[i], PG_RX_LOW_MV);
      end
    end
  endgenerate

  assign anyEn = |enVec;
  assign allEnabledOk = &pgOk;

  // Registers
  logic [CTRL_CAP_W-1:0] capNf_reg;
  logic [IRQ_W-1:0] irqMask_reg;
  logic [IRQ_W-1:0] irqStat_reg;
  logic [IRQ_W-1:0] irqEvent;

  // Capacitor-scaled time base
  logic [15:0] unitCnt_reg;
  logic [CTRL_CAP_W-1:0] scaleCnt_reg;
  logic tick;
  logic [CTRL_CAP_W-1:0] scaleTop;

  // A zero capacitor code behaves as the smallest capacitor
  assign scaleTop = (capNf_reg == '0) ? '0 : capNf_reg - 1'b1;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      unitCnt_reg <= '0;
      scaleCnt_reg <= '0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (unitCnt_reg == 16'(UNIT_CYC - 1)) begin
        unitCnt_reg <= '0;
        if (scaleCnt_reg >= scaleTop) begin
          scaleCnt_reg <= '0;
          tick <= 1'b1;
        end else begin
          scaleCnt_reg <= scaleCnt_reg + 1'b1;
        end
      end else begin
        unitCnt_reg <= unitCnt_reg + 1'b1;
      end
    end
  end

  // Service input synchroniser and edge detector
  logic svcMeta_reg;
  logic svcSync_reg;
  logic svcLast_reg;
  logic svcEdge;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      svcMeta_reg <= 1'b0;
      svcSync_reg <= 1'b0;
      svcLast_reg <= 1'b0;
    end else begin
      svcMeta_reg <= watchdog_service_in;
      svcSync_reg <= svcMeta_reg;
      svcLast_reg <= svcSync_reg;
    end
  end

  assign svcEdge = svcSync_reg ^ svcLast_reg;

  // Watchdog state machine
  wd_state_t wdState_reg;
  logic [UNIT_W-1:0] wdCnt_reg;
  logic [UNIT_W-1:0] sinceLow_reg;
  logic wdoStart;

  // Reset leaves the machine in its low period, so every UVLO ends in a timeout
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wdState_reg <= WD_LOW;
      wdCnt_reg <= '0;
      sinceLow_reg <= '0;
    end else if (timing_cap_pin) begin
      wdState_reg <= WD_OFF;
      wdCnt_reg <= '0;
      sinceLow_reg <= '0;
    end else begin
      if (tick) begin
        sinceLow_reg <= sinceLow_reg + 1'b1;
      end
      unique case (wdState_reg)
        WD_OFF: begin
          wdState_reg <= WD_SERVICED;
          wdCnt_reg <= '0;
        end
        WD_LOW: begin
          // Edges during the low period are not counted as service
          if (tick) begin
            if (wdCnt_reg == WD_LOW_UNITS - 1'b1) begin
              wdState_reg <= WD_AFTER_LOW;
              wdCnt_reg <= '0;
            end else begin
              wdCnt_reg <= wdCnt_reg + 1'b1;
            end
          end
        end
        WD_AFTER_LOW: begin
          if (svcEdge) begin
            wdState_reg <= WD_SERVICED;
            wdCnt_reg <= '0;
          end else if (tick && sinceLow_reg == WD_REPEAT_UNITS - 1'b1) begin
            wdState_reg <= WD_LOW;
            wdCnt_reg <= '0;
            sinceLow_reg <= '0;
          end
        end
        WD_SERVICED: begin
          if (svcEdge) begin
            wdCnt_reg <= '0;
          end else if (tick) begin
            if (wdCnt_reg == WD_SERVICE_UNITS - 1'b1) begin
              wdState_reg <= WD_LOW;
              wdCnt_reg <= '0;
              sinceLow_reg <= '0;
            end else begin
              wdCnt_reg <= wdCnt_reg + 1'b1;
            end
          end
        end
      endcase
    end
  end

  assign wdoStart = !timing_cap_pin && tick &&
    ((wdState_reg == WD_SERVICED && !svcEdge && wdCnt_reg == WD_SERVICE_UNITS - 1'b1) ||
     (wdState_reg == WD_AFTER_LOW && !svcEdge && sinceLow_reg == WD_REPEAT_UNITS - 1'b1));

  // Open-drain pin: data is always low, only the enable moves
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_timeout_out_oe <= 1'b1;
      watchdog_timeout_out_o <= 1'b0;
    end else begin
      watchdog_timeout_out_o <= 1'b0;
      watchdog_timeout_out_oe <= !timing_cap_pin &&
        ((wdState_reg == WD_LOW && !(tick && wdCnt_reg == WD_LOW_UNITS - 1'b1)) || wdoStart);
    end
  end

  // Reset supervisor
  logic [UNIT_W-1:0] rstCnt_reg;
  logic rstLow;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstCnt_reg <= '0;
    end else if (!anyEn || !allEnabledOk) begin
      rstCnt_reg <= '0;
    end else if (tick && rstCnt_reg != RST_DELAY_UNITS) begin
      rstCnt_reg <= rstCnt_reg + 1'b1;
    end
  end

  assign rstLow = !anyEn || !allEnabledOk || (rstCnt_reg != RST_DELAY_UNITS);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstOut_oe <= 1'b1;
      rstOut_o <= 1'b0;
    end else begin
      rstOut_o <= 1'b0;
      rstOut_oe <= rstLow;
    end
  end

  // Straps, oscillator and light-load mode
  logic [2:0] syncDivCnt_reg;
  logic syncLast_reg;
  logic syncRise;

  assign syncRise = syncClkIn && !syncLast_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      syncLast_reg <= 1'b0;
      syncDivCnt_reg <= '0;
      lvSyncPulse <= 1'b0;
      hvSyncPulse <= 1'b0;
    end else begin
      syncLast_reg <= syncClkIn;
      lvSyncPulse <= syncPresent && syncRise;
      hvSyncPulse <= 1'b0;
      if (!syncPresent) begin
        syncDivCnt_reg <= '0;
      end else if (syncRise) begin
        if (syncDivCnt_reg == HV_SYNC_DIV - 1'b1) begin
          syncDivCnt_reg <= '0;
          hvSyncPulse <= 1'b1;
        end else begin
          syncDivCnt_reg <= syncDivCnt_reg + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stageConfig <= '0;
      internalOscSel <= 1'b0;
      forcedCont <= 1'b0;
      lvBurst <= 1'b0;
      hvBurst <= 1'b0;
      hvSkip <= 1'b0;
      tempMonEnable <= 1'b0;
    end else begin
      stageConfig <= {stage_config_bit2, stage_config_bit1, stage_config_bit0};
      internalOscSel <= freq_set_pin && !syncPresent;
      tempMonEnable <= anyEn;
      // A synchronised clock implies forced continuous operation
      forcedCont <= syncPresent || (mode_level_t'(modeLevel) == MODE_RAIL);
      lvBurst <= !syncPresent && (mode_level_t'(modeLevel) inside {MODE_GND, MODE_MID,
        MODE_RSVD});
      hvBurst <= !syncPresent && (mode_level_t'(modeLevel) inside {MODE_GND, MODE_RSVD});
      hvSkip <= !syncPresent && (mode_level_t'(modeLevel) == MODE_MID);
    end
  end

  // Interrupt events
  logic rstLowLast_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstLowLast_reg <= 1'b1;
    end else begin
      rstLowLast_reg <= rstLow;
    end
  end

  assign irqEvent[IRQ_WDO] = wdoStart;
  assign irqEvent[IRQ_RST_LOW] = rstLow && !rstLowLast_reg;
  assign irqEvent[IRQ_RST_REL] = !rstLow && rstLowLast_reg;

  // APB slave: one wait state, registered answer
  logic apbAccess;
  logic apbDone;
  logic addrOk;
  logic [31:0] readMux;

  assign apbAccess = psel && penable && !pready;
  assign apbDone = psel && penable && pready;
  assign addrOk = paddr inside {CTRL_OFF, STATUS_OFF, IRQ_STAT_OFF, IRQ_MASK_OFF};

  always_comb begin
    readMux = '0;
    unique case (paddr)
      CTRL_OFF: readMux[CTRL_CAP_LSB +: CTRL_CAP_W] = capNf_reg;
      STATUS_OFF: begin
        readMux[ST_WDO] = watchdog_timeout_out_oe;
        readMux[ST_RST] = rstOut_oe;
        readMux[ST_WDOFF] = (wdState_reg == WD_OFF);
        readMux[ST_PG_LSB +: 4] = pgOk;
        readMux[ST_EN_LSB +: 4] = enVec;
        readMux[ST_CFG_LSB +: 3] = stageConfig;
        readMux[ST_STATE_LSB +: 2] = wdState_reg;
      end
      IRQ_STAT_OFF: readMux[IRQ_W-1:0] = irqStat_reg;
      IRQ_MASK_OFF: readMux[IRQ_W-1:0] = irqMask_reg;
      default: readMux = '0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !addrOk;
      prdata <= (apbAccess && !pwrite) ? readMux : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      capNf_reg <= CAP_NF_RESET;
      irqMask_reg <= IRQ_MASK_RESET;
    end else if (apbDone && pwrite) begin
      if (paddr == CTRL_OFF) begin
        capNf_reg <= pwdata[CTRL_CAP_LSB +: CTRL_CAP_W];
      end
      if (paddr == IRQ_MASK_OFF) begin
        irqMask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Read clears the sticky bits; a new event in that cycle survives
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irqStat_reg <= '0;
    end else begin
      if (apbDone && !pwrite && paddr == IRQ_STAT_OFF) begin
        irqStat_reg <= irqEvent;
      end else begin
        irqStat_reg <= irqStat_reg | irqEvent;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |((irqStat_reg | irqEvent) & irqMask_reg);
    end
  end

endmodule : watchdog_reset_supervisor
`default_nettype wire

// file: rtl/wd_supervisor_pkg.sv
// Constants shared by the watchdog and reset supervisor
package wd_supervisor_pkg;

  // APB register byte offsets
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h0C;

  // Control register fields and reset values
  localparam int CTRL_CAP_LSB = 0;
  localparam int CTRL_CAP_W = 8;
  localparam logic [7:0] CAP_NF_RESET = 8'h0A;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // Status register field positions
  localparam int ST_WDO = 0;
  localparam int ST_RST = 1;
  localparam int ST_WDOFF = 2;
  localparam int ST_PG_LSB = 4;
  localparam int ST_EN_LSB = 8;
  localparam int ST_CFG_LSB = 12;
  localparam int ST_STATE_LSB = 16;

  // Interrupt bits
  localparam int IRQ_WDO = 0;
  localparam int IRQ_RST_LOW = 1;
  localparam int IRQ_RST_REL = 2;
  localparam int IRQ_W = 3;

  // Time base: one unit is 0.01 ms per nF of timing capacitor
  localparam real CLK_MHZ = 100.0;
  localparam real UNIT_US_PER_NF = 10.0;
  localparam int UNIT_CYC_PER_NF = int'(UNIT_US_PER_NF * CLK_MHZ);
  // Delays at the nominal 10 nF capacitor, in ms, counted in units of 0.1 ms
  localparam real NOMINAL_NF = 10.0;
  localparam real UNIT_MS_NOMINAL = UNIT_US_PER_NF * NOMINAL_NF / 1000.0;
  localparam real WD_SERVICE_MS = 1620.0;
  localparam real WD_REPEAT_MS = 12900.0;
  localparam real WD_LOW_MS = 202.0;
  localparam real RST_DELAY_MS = 202.0;
  localparam int UNIT_W = 17;
  localparam logic [UNIT_W-1:0] WD_SERVICE_UNITS = UNIT_W'(int'(WD_SERVICE_MS / UNIT_MS_NOMINAL));
  localparam logic [UNIT_W-1:0] WD_REPEAT_UNITS = UNIT_W'(int'(WD_REPEAT_MS / UNIT_MS_NOMINAL));
  localparam logic [UNIT_W-1:0] WD_LOW_UNITS = UNIT_W'(int'(WD_LOW_MS / UNIT_MS_NOMINAL));
  localparam logic [UNIT_W-1:0] RST_DELAY_UNITS = UNIT_W'(int'(RST_DELAY_MS / UNIT_MS_NOMINAL));

  // Power-good window around 800 mV feedback, in mV
  localparam int FB_W = 10;
  localparam logic [FB_W-1:0] PG_R1_LOW_MV = 10'd784;
  localparam logic [FB_W-1:0] PG_RX_LOW_MV = 10'd760;
  localparam logic [FB_W-1:0] PG_HIGH_MV = 10'd860;

  // External sync to high-voltage controller ratio
  localparam logic [2:0] HV_SYNC_DIV = 3'd6;

  // Light-load mode pin levels
  typedef enum logic [1:0] {MODE_GND, MODE_MID, MODE_RAIL, MODE_RSVD} mode_level_t;

  typedef enum logic [1:0] {WD_OFF, WD_LOW, WD_AFTER_LOW, WD_SERVICED} wd_state_t;

endpackage : wd_supervisor_pkg

// file: verif/host_model.sv
// Host model that services the watchdog input
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int PERIOD = 20000
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Service control and pin
  input wire logic serviceOn,
  output var logic watchdog_service_in
);
  int cnt;
  // First toggle at once, then well inside the service interval
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
    end else if (!serviceOn || cnt == 0) begin
      cnt <= serviceOn ? PERIOD - 1 : 0;
    end else begin
      cnt <= cnt - 1;
    end
  end
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_service_in <= 1'b0;
    end else if (serviceOn && cnt == 0) begin
      watchdog_service_in <= ~watchdog_service_in;
    end
  end
endmodule : host_model
`default_nettype wire

// file: verif/watchdog_reset_supervisor_test.sv
// Self-checking bench for the watchdog and reset supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin numErrors++; \
$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
`define WAITV(s, v, lim) begin n = 0; while ((s) !== (v) && n < (lim)) begin \
@(posedge clk_sys); n++; end if ((s) !== (v)) begin numErrors++; wrap_up(); end end
module watchdog_reset_supervisor_test;
  import wd_supervisor_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, watchdog_service_in, watchdog_timeout_out_o, rstOut_o, rstOut_oe;
  logic watchdog_timeout_out_oe, serviceOn = 1'b0, timing_cap_pin = 1'b0, last;
  logic reg1_enable = 1'b0, reg2_enable = 1'b0, reg3_enable = 1'b0, reg4_enable = 1'b0;
  logic [FB_W-1:0] reg1_feedback = '0, reg2_feedback = '0, reg3_feedback = '0, reg4_feedback = '0;
  logic stage_config_bit0 = 1'b0, stage_config_bit1 = 1'b0, stage_config_bit2 = 1'b0;
  logic freq_set_pin = 1'b0, syncPresent = 1'b0, syncClkIn = 1'b0;
  logic [1:0] modeLevel = 2'h0;
  logic [2:0] stageConfig;
  logic internalOscSel, lvSyncPulse, hvSyncPulse, forcedCont, lvBurst, hvBurst, hvSkip;
  logic tempMonEnable;
  logic [33:0] rdNote;
  logic [33:0] expQ[$];
  int numErrors = 0, totalChecks = 0, n, i, k, lvCnt = 0, hvCnt = 0;
  // Open-drain pin with its pull-up
  wire logic wdoPin = watchdog_timeout_out_oe ? watchdog_timeout_out_o : 1'b1;
  watchdog_reset_supervisor #(.UNIT_CYC(2)) uut (
    .clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irq, .watchdog_service_in, .timing_cap_pin, .watchdog_timeout_out_o,
    .watchdog_timeout_out_oe, .reg1_enable, .reg2_enable, .reg3_enable, .reg4_enable,
    .reg1_feedback, .reg2_feedback, .reg3_feedback, .reg4_feedback, .rstOut_o, .rstOut_oe,
    .stage_config_bit0, .stage_config_bit1, .stage_config_bit2, .freq_set_pin, .syncPresent,
    .syncClkIn, .modeLevel, .stageConfig, .internalOscSel, .lvSyncPulse, .hvSyncPulse,
    .forcedCont, .lvBurst, .hvBurst, .hvSkip, .tempMonEnable
  );
  host_model #(.PERIOD(20000)) host (.clk_sys, .rst_b, .serviceOn, .watchdog_service_in);
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // Note is {care, slverr, data}; held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [33:0] e);
    int t;
    if (!w) expQ.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (pready !== 1'b1 && t < 20);
    if (pready !== 1'b1) begin
      numErrors++;
      wrap_up();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  always @(posedge clk_sys) begin
    lvCnt += int'(lvSyncPulse === 1'b1);
    hvCnt += int'(hvSyncPulse === 1'b1);
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      rdNote = expQ.pop_front();
      if (rdNote[33]) `CHK("read", rdNote[32:0], {pslverr, prdata})
    end
  end
  initial begin
    void'($urandom(32'h1740));
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    `CHK("wdo in reset", 1'b1, watchdog_timeout_out_oe)
    @(posedge clk_sys);
    apb(1'b0, CTRL_OFF, 32'h0, 34'h2_0000_000A);
    apb(1'b0, IRQ_MASK_OFF, 32'h0, 34'h2_0000_0000);
    apb(1'b0, 8'h10, 32'h0, 34'h3_0000_0000);
    apb(1'b1, CTRL_OFF, 32'h1, 34'h0);
    apb(1'b0, CTRL_OFF, 32'h0, 34'h2_0000_0001);
    `WAITV(watchdog_timeout_out_oe, 1'b0, 60000)
    `CHK("reset idle", 1'b1, rstOut_oe)
    `CHK("temp off", 1'b0, tempMonEnable)
    for (i = 0; i < 16; i++) begin
      {stage_config_bit2, stage_config_bit1, stage_config_bit0} <= i[2:0];
      {freq_set_pin, syncPresent, modeLevel} <= i[3:0];
      repeat (3) @(posedge clk_sys);
      `CHK("stages", i[2:0], stageConfig)
      `CHK("modes", {i[3] & ~i[2], i[2] | (i[1:0] == 2'h2), ~i[2] & (i[1:0] != 2'h2),
        ~i[2] & (i[1:0] == 2'h0 | i[1:0] == 2'h3), ~i[2] & (i[1:0] == 2'h1)},
        {internalOscSel, forcedCont, lvBurst, hvBurst, hvSkip})
    end
    syncPresent <= 1'b1;
    for (i = 0; i < 24; i++) begin
      syncClkIn <= ~syncClkIn;
      repeat (3) @(posedge clk_sys);
    end
    syncPresent <= 1'b0;
    repeat (4) @(posedge clk_sys);
    `CHK("lv sync", 12, lvCnt)
    `CHK("hv sync", 2, hvCnt)
    apb(1'b0, IRQ_STAT_OFF, 32'h0, 34'h2_0000_0000);
    apb(1'b1, IRQ_MASK_OFF, 32'h7, 34'h0);
    reg1_feedback <= PG_R1_LOW_MV + FB_W'($urandom_range(76));
    reg4_feedback <= PG_RX_LOW_MV + FB_W'($urandom_range(100));
    reg1_enable <= 1'b1;
    reg4_enable <= 1'b1;
    @(posedge clk_sys);
    `WAITV(rstOut_oe, 1'b0, 5000)
    `CHK("release delay", 1'b1, n >= 4040 && n <= 4048)
    `CHK("irq release", 1'b1, irq)
    apb(1'b0, IRQ_STAT_OFF, 32'h0, 34'h2_0000_0004);
    // Level drops one cycle after the clearing edge
    @(posedge clk_sys);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b1, IRQ_MASK_OFF, 32'h3, 34'h0);
    reg1_feedback <= PG_R1_LOW_MV - 10'd1;
    repeat (4) @(posedge clk_sys);
    `CHK("reg1 low", 1'b1, rstOut_oe)
    `CHK("irq reset low", 1'b1, irq)
    apb(1'b0, IRQ_STAT_OFF, 32'h0, 34'h2_0000_0002);
    reg1_feedback <= PG_R1_LOW_MV;
    `WAITV(rstOut_oe, 1'b0, 5000)
    `CHK("masked irq", 1'b0, irq)
    apb(1'b0, IRQ_STAT_OFF, 32'h0, 34'h2_0000_0004);
    reg2_feedback <= PG_RX_LOW_MV - 10'd1;
    reg2_enable <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK("reg2 low", 1'b1, rstOut_oe)
    serviceOn <= 1'b1;
    last = watchdog_service_in;
    k = 0;
    n = 0;
    while (k < 2 && n < 30000) begin
      @(posedge clk_sys);
      n++;
      if (watchdog_service_in !== last) begin
        k++;
        last = watchdog_service_in;
      end
    end
    serviceOn <= 1'b0;
    `CHK("service toggles", 2, k)
    `WAITV(watchdog_timeout_out_oe, 1'b1, 40000)
    `CHK("service timeout", 1'b1, n >= 32396 && n <= 32408)
    `CHK("wdo pin", 1'b0, wdoPin)
    `WAITV(watchdog_timeout_out_oe, 1'b0, 5000)
    `CHK("low period", 1'b1, n >= 4036 && n <= 4046)
    // Mid-run reset with the watchdog strapped off
    rst_b <= 1'b0;
    timing_cap_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
    `CHK("wdo on reset", 1'b1, watchdog_timeout_out_oe)
    rst_b <= 1'b1;
    // Long enough for the strap assertion to finish its window
    repeat (6) @(posedge clk_sys);
    `CHK("wd disabled", 1'b0, watchdog_timeout_out_oe)
    wrap_up();
  end
endmodule : watchdog_reset_supervisor_test
bind watchdog_reset_supervisor wd_supervisor_chk chk (
  .clk_sys, .rst_b, .psel, .penable, .pready, .pslverr, .watchdog_timeout_out_o,
  .watchdog_timeout_out_oe, .timing_cap_pin, .reg1_enable, .reg2_enable, .reg3_enable,
  .reg4_enable, .reg1_feedback, .reg2_feedback, .reg3_feedback, .reg4_feedback, .rstOut_o,
  .rstOut_oe, .tempMonEnable, .stage_config_bit0, .stage_config_bit1, .stage_config_bit2,
  .stageConfig
);
`default_nettype wire

// file: verif/wd_supervisor_chk.sv
// Port assertions for the watchdog and reset supervisor
`timescale 1ns/1ps
`default_nettype none
module wd_supervisor_chk
  import wd_supervisor_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Watchdog
  input wire logic watchdog_timeout_out_o,
  input wire logic watchdog_timeout_out_oe,
  input wire logic timing_cap_pin,
  // Regulators
  input wire logic reg1_enable,
  input wire logic reg2_enable,
  input wire logic reg3_enable,
  input wire logic reg4_enable,
  input wire logic [FB_W-1:0] reg1_feedback,
  input wire logic [FB_W-1:0] reg2_feedback,
  input wire logic [FB_W-1:0] reg3_feedback,
  input wire logic [FB_W-1:0] reg4_feedback,
  input wire logic rstOut_o,
  input wire logic rstOut_oe,
  input wire logic tempMonEnable,
  // Straps
  input wire logic stage_config_bit0,
  input wire logic stage_config_bit1,
  input wire logic stage_config_bit2,
  input wire logic [2:0] stageConfig
);
  logic anyEn;
  logic goodNow;
  logic [2:0] strapNow;
  logic [4:0] goodCnt;
  function automatic logic inWin(input logic [FB_W-1:0] fb, input logic [FB_W-1:0] lo);
    return fb >= lo && fb <= PG_HIGH_MV;
  endfunction : inWin
  assign anyEn = reg1_enable | reg2_enable | reg3_enable | reg4_enable;
  assign goodNow = anyEn && (!reg1_enable || inWin(reg1_feedback, PG_R1_LOW_MV))
    && (!reg2_enable || inWin(reg2_feedback, PG_RX_LOW_MV))
    && (!reg3_enable || inWin(reg3_feedback, PG_RX_LOW_MV))
    && (!reg4_enable || inWin(reg4_feedback, PG_RX_LOW_MV));
  assign strapNow = {stage_config_bit2, stage_config_bit1, stage_config_bit0};
  // Saturates, so release is only judged against a minimum good run
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      goodCnt <= 5'h00;
    end else if (!goodNow) begin
      goodCnt <= 5'h00;
    end else if (goodCnt != 5'h1F) begin
      goodCnt <= goodCnt + 5'h01;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  sequence accessWait;
    psel && penable && !pready;
  endsequence
  sequence readyPulse;
    pready ##1 !pready;
  endsequence
  wdo_sink_only_a: assert property (!watchdog_timeout_out_o) else $error("wdo driven high");
  rst_sink_only_a: assert property (!rstOut_o) else $error("reset driven high");
  apb_answer_a: assert property (accessWait |=> readyPulse) else $error("bad ready");
  rst_all_off_a: assert property ((!anyEn) [*3] |-> rstOut_oe) else $error("reset free");
  rst_bad_fb_a: assert property ((anyEn && !goodNow) [*3] |-> rstOut_oe)
    else $error("reset free on bad feedback");
  rst_release_a: assert property ($fell(rstOut_oe) |-> goodCnt >= 5'h10)
    else $error("early release");
  wd_disable_a: assert property (timing_cap_pin [*4] |-> !watchdog_timeout_out_oe)
    else $error("wdo while disabled");
  wd_low_len_a: assert property ($rose(watchdog_timeout_out_oe) |=> watchdog_timeout_out_oe [*8])
    else $error("short wdo");
  temp_mon_a: assert property (anyEn [*2] |-> tempMonEnable) else $error("temp off");
  stage_cfg_a: assert property ($stable(strapNow) [*2] |-> stageConfig == strapNow)
    else $error("stage config");
endmodule : wd_supervisor_chk
`default_nettype wire
